// [logic/pin_remap_pkg.sv]
// constants shared by the pin remap selector and its helper modules
// assumes one system clock; pin indices count port*8+line, port a = 0
package pin_remap_pkg;
  localparam int NUM_PORTS = 8;
  localparam int PORT_W = 8;
  localparam int NUM_PINS = 64;
  localparam int NUM_TOUT = 9;
  localparam int NUM_TIN = 6;

  // wishbone byte offsets
  localparam logic [7:0] OFS_IN_REMAP = 8'h00;
  localparam logic [7:0] OFS_OUT_REMAP = 8'h04;
  localparam logic [7:0] OFS_BITOP = 8'h08;
  localparam logic [7:0] OFS_WAKE_EN = 8'h0c;
  localparam logic [2:0] REGION_DATA = 3'h1;
  localparam logic [2:0] REGION_DIR = 3'h2;

  localparam logic [7:0] REMAP_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [7:0] WAKE_EN_RST = 8'h00;
  // irq 0 and irq 1 inputs are active low, so they idle high out of reset
  localparam logic [5:0] TIN_RST = 6'h18;

  // implemented select bits per variant, smallest = 0, largest = 3
  localparam logic [7:0] IN_MASK [4] = '{8'h6f, 8'hef, 8'hef, 8'hff};
  localparam logic [7:0] OUT_MASK [4] = '{8'h07, 8'h3f, 8'hff, 8'hff};

  // bit operation word
  localparam int BITOP_LINE_LSB = 0;
  localparam int BITOP_PORT_LSB = 3;
  localparam int BITOP_VAL_BIT = 6;
  localparam int BITOP_DIR_BIT = 7;

  // timer output index
  localparam int TOUT_CHAN_A = 0;
  localparam int TOUT_CHAN_B_FIRST = 1;
  localparam int TOUT_CHAN_B_SECOND = 2;
  localparam int TOUT_T0_FIRST = 3;
  localparam int TOUT_T0_SECOND = 4;
  localparam int TOUT_T2_FIRST = 5;
  localparam int TOUT_T2_SECOND = 6;
  localparam int TOUT_T3_FIRST = 7;
  localparam int TOUT_T3_SECOND = 8;
  // select bit: [3] 1 = output remap register, [2:0] bit
  localparam logic [3:0] TOUT_SEL [9] = '{4'ha, 4'h0, 4'h1, 4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf};
  localparam logic [5:0] TOUT_PIN0 [9] = '{6'h01, 6'h10, 6'h11, 6'h00, 6'h15, 6'h13, 6'h14, 6'h33, 6'h30};
  localparam logic [5:0] TOUT_PIN1 [9] = '{6'h1a, 6'h1b, 6'h1c, 6'h18, 6'h19, 6'h1e, 6'h1f, 6'h28, 6'h29};
  localparam logic [1:0] TOUT_MIN_VAR [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
  localparam logic [5:0] T0_SECOND_SMALL_PIN = 6'h07;

  // timer input index
  localparam int TIN_TIMER0_EXT_CLOCK_IN = 0;
  localparam int TIN_TIMER1_EXT_CLOCK_IN = 1;
  localparam int TIN_TIMER2_EXT_CLOCK_IN = 2;
  localparam int TIN_IRQ0 = 3;
  localparam int TIN_IRQ1 = 4;
  localparam int TIN_IRQ2 = 5;
  localparam logic [2:0] TIN_SEL [6] = '{3'h5, 3'h6, 3'h7, 3'h2, 3'h3, 3'h4};
  localparam logic [5:0] TIN_PIN0 [6] = '{6'h02, 6'h04, 6'h12, 6'h03, 6'h04, 6'h14};
  localparam logic [5:0] TIN_PIN1 [6] = '{6'h20, 6'h21, 6'h22, 6'h24, 6'h25, 6'h26};
  localparam logic [1:0] TIN_MIN_VAR [6] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h3};
endpackage

// [logic/pin_sync2.sv]
// two-flop synchroniser for a vector of pin levels
// assumes each bit is an independent level; no bus coherency is given
module pin_sync2
  import pin_remap_pkg::*;
#(
  parameter int W = NUM_PINS
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  // pins idle high through their pull-ups, so reset to ones
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_reg <= '1;
      o_sync <= '1;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

// [logic/port_regs.sv]
// port data and direction registers for all ports
// assumes at most one write strobe per port per cycle from the bus side
module port_regs
  import pin_remap_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [NUM_PORTS-1:0] i_data_we,
  input wire logic [NUM_PORTS-1:0] i_dir_we,
  input wire logic [PORT_W-1:0] i_wdata,
  output logic [NUM_PINS-1:0] o_data,
  output logic [NUM_PINS-1:0] o_dir
);
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        o_data[p*PORT_W +: PORT_W] <= PORT_RST;
        o_dir[p*PORT_W +: PORT_W] <= PORT_RST;
      end else begin
        if (i_data_we[p]) begin
          o_data[p*PORT_W +: PORT_W] <= i_wdata;
        end
        if (i_dir_we[p]) begin
          o_dir[p*PORT_W +: PORT_W] <= i_wdata;
        end
      end
    end
  end
endmodule

// [logic/pin_remap_selector.sv]
// pin remap selector: remap select registers, port registers, wake-up
// assumes a classic wishbone master on i_sys_clk and raw pins from outside
//
// Summary of operation
// - timer 1 clock from A4, or E1 when input remap bit 6 set.
// - timer 0 clock from A2, or E0 when input remap bit 5 set.
// - timer 2 clock from C2, or E2 by bit 7, if timer 2 exists.
// - irq 1 (low) from A4, or E5 when input remap bit 3 set.
// - irq 0 (low) from A3, or E4 when input remap bit 2 set.
// - largest variant only: irq 2 from C4, or E6 by bit 4; else zero.
// - channel b second output on C1, or D4 when input remap bit 1 set.
// - channel b first output on C0, or D3 when input remap bit 0 set.
// - channel a output on A1, or D2 when output remap bit 2 set.
// - timer 0 second on D1 when bit 1 set; else A7 smallest, C5 others.
// - timer 0 first output on A0, or D0 when output remap bit 0 set.
// - timer 2 second output on C4, or D7 when output remap bit 5 set.
// - timer 2 first output on C3, or D6 when output remap bit 4 set.
// - timer 3 second output on G0, or F1 when output remap bit 7 set.
// - timer 3 first output on G3, or F0 when output remap bit 6 set.
// - select bits reset to zero; missing bits read zero, ignore writes.
// - port data and direction registers reset to all ones.
// - an output pin drives its data register, high after reset.
// - single-bit set or clear reads whole port, changes bit, writes all.
// - in sleep, a falling edge on an enabled port a pin wakes.
// - direction bit 0 makes the pin output, 1 makes it input.
module pin_remap_selector
  import pin_remap_pkg::*;
#(
  parameter logic [1:0] VARIANT = 2'h3
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [NUM_PINS-1:0] i_pin_in,
  output logic [NUM_PINS-1:0] o_pin_out,
  output logic [NUM_PINS-1:0] o_pin_oe,
  input wire logic [NUM_TOUT-1:0] i_timer_out,
  input wire logic [NUM_TOUT-1:0] i_timer_out_en,
  output logic o_timer0_ext_clock_in,
  output logic o_timer1_ext_clock_in,
  output logic o_timer2_ext_clock_in,
  output logic o_ext_irq0_in_n,
  output logic o_ext_irq1_in_n,
  output logic o_ext_irq2_in,
  input wire logic i_sleep,
  output logic o_wake
);
  logic [7:0] input_remap_select_reg;
  logic [7:0] timer_output_remap_select_reg;
  logic [7:0] wake_en_reg;
  logic [7:0] porta_prev_reg;
  logic ack_reg;
  logic [NUM_PINS-1:0] pin_s;
  logic [NUM_PINS-1:0] data_q;
  logic [NUM_PINS-1:0] dir_q;
  logic [NUM_PINS-1:0] port_val;
  logic [NUM_PORTS-1:0] data_we;
  logic [NUM_PORTS-1:0] dir_we;
  logic [PORT_W-1:0] port_wdata;
  logic [NUM_PINS-1:0] ovr_hit;
  logic [NUM_PINS-1:0] ovr_val;
  logic [NUM_PINS-1:0] pin_out_next;
  logic [NUM_PINS-1:0] pin_oe_next;
  logic [5:0] tout_pin [NUM_TOUT];
  logic [NUM_TOUT-1:0] tout_live;
  logic [NUM_TIN-1:0] tin_next;
  logic [NUM_TIN-1:0] tin_reg;
  logic bus_req;
  logic bus_wr;
  logic bitop_go;
  logic [2:0] bitop_port;
  logic [2:0] bitop_line;
  logic [PORT_W-1:0] bitop_old;
  logic [PORT_W-1:0] bitop_new;
  logic [7:0] rd_next;
  logic [7:0] fall;

  // ****************************************
  // pin synchroniser and port registers
  // ****************************************
  pin_sync2 #(.W(NUM_PINS)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_async(i_pin_in),
    .o_sync(pin_s)
  );

  port_regs u_ports (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_data_we(data_we),
    .i_dir_we(dir_we),
    .i_wdata(port_wdata),
    .o_data(data_q),
    .o_dir(dir_q)
  );

  // reading a port shows the pin for inputs and the latch for outputs
  assign port_val = (dir_q & pin_s) | (~dir_q & data_q);

  // ****************************************
  // wishbone slave
  // ****************************************
  // one wait state: ack comes the cycle after the request and then drops
  assign bus_req = i_wb_cyc && i_wb_stb && !ack_reg;
  assign bus_wr = bus_req && i_wb_we && i_wb_sel[0];
  assign o_wb_ack = ack_reg;
  assign bitop_go = bus_wr && (i_wb_adr == OFS_BITOP);
  assign bitop_port = i_wb_dat[BITOP_PORT_LSB +: 3];
  assign bitop_line = i_wb_dat[BITOP_LINE_LSB +: 3];

  // bit operation snapshots the whole port, edits one bit, writes all
  always_comb begin
    bitop_old = i_wb_dat[BITOP_DIR_BIT] ? dir_q[bitop_port*PORT_W +: PORT_W]
                                        : port_val[bitop_port*PORT_W +: PORT_W];
    bitop_new = bitop_old;
    bitop_new[bitop_line] = i_wb_dat[BITOP_VAL_BIT];
  end

  always_comb begin
    data_we = '0;
    dir_we = '0;
    port_wdata = i_wb_dat[7:0];
    if (bitop_go) begin
      port_wdata = bitop_new;
      if (i_wb_dat[BITOP_DIR_BIT]) begin
        dir_we[bitop_port] = 1'b1;
      end else begin
        data_we[bitop_port] = 1'b1;
      end
    end else if (bus_wr && i_wb_adr[7:5] == REGION_DATA) begin
      data_we[i_wb_adr[4:2]] = 1'b1;
    end else if (bus_wr && i_wb_adr[7:5] == REGION_DIR) begin
      dir_we[i_wb_adr[4:2]] = 1'b1;
    end
  end

  always_comb begin
    rd_next = 8'h00;
    if (i_wb_adr == OFS_IN_REMAP) begin
      rd_next = input_remap_select_reg;
    end else if (i_wb_adr == OFS_OUT_REMAP) begin
      rd_next = timer_output_remap_select_reg;
    end else if (i_wb_adr == OFS_WAKE_EN) begin
      rd_next = wake_en_reg;
    end else if (i_wb_adr[7:5] == REGION_DATA && i_wb_adr[1:0] == 2'h0) begin
      rd_next = port_val[i_wb_adr[4:2]*PORT_W +: PORT_W];
    end else if (i_wb_adr[7:5] == REGION_DIR && i_wb_adr[1:0] == 2'h0) begin
      rd_next = dir_q[i_wb_adr[4:2]*PORT_W +: PORT_W];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_reg <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req;
      if (bus_req) begin
        o_wb_dat <= {24'h00_0000, rd_next};
      end
    end
  end

  // ****************************************
  // remap and wake enable registers
  // ****************************************
  // zero at reset; missing bits masked so they stay zero
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      input_remap_select_reg <= REMAP_RST;
      timer_output_remap_select_reg <= REMAP_RST;
      wake_en_reg <= WAKE_EN_RST;
    end else if (bus_wr) begin
      if (i_wb_adr == OFS_IN_REMAP) begin
        input_remap_select_reg <= i_wb_dat[7:0] & IN_MASK[VARIANT];
      end
      if (i_wb_adr == OFS_OUT_REMAP) begin
        timer_output_remap_select_reg <= i_wb_dat[7:0] & OUT_MASK[VARIANT];
      end
      if (i_wb_adr == OFS_WAKE_EN) begin
        wake_en_reg <= i_wb_dat[7:0];
      end
    end
  end

  // ****************************************
  // timer output routing
  // ****************************************
  for (genvar k = 0; k < NUM_TOUT; k++) begin : g_tout
    logic sel;
    assign sel = TOUT_SEL[k][3] ? timer_output_remap_select_reg[TOUT_SEL[k][2:0]]
                                : input_remap_select_reg[TOUT_SEL[k][2:0]];
    assign tout_pin[k] = sel ? TOUT_PIN1[k] :
                         (k == TOUT_T0_SECOND && VARIANT == 2'h0) ? T0_SECOND_SMALL_PIN : TOUT_PIN0[k];
    assign tout_live[k] = i_timer_out_en[k] && (TOUT_MIN_VAR[k] <= VARIANT);
  end

  // only the chosen pin is taken over, all others keep port logic
  always_comb begin
    ovr_hit = '0;
    ovr_val = '0;
    for (int k = 0; k < NUM_TOUT; k++) begin
      if (tout_live[k]) begin
        ovr_hit[tout_pin[k]] = 1'b1;
        ovr_val[tout_pin[k]] = i_timer_out[k];
      end
    end
  end

  // port output drives latch when direction bit is 0
  assign pin_out_next = (ovr_hit & ovr_val) | (~ovr_hit & data_q);
  assign pin_oe_next = ovr_hit | ~dir_q;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pin_out <= '1;
      o_pin_oe <= '0;
    end else begin
      o_pin_out <= pin_out_next;
      o_pin_oe <= pin_oe_next;
    end
  end

  // ****************************************
  // timer clock and interrupt input routing
  // ****************************************
  for (genvar j = 0; j < NUM_TIN; j++) begin : g_tin
    // sample chosen pin, absent functions idle
    assign tin_next[j] = (TIN_MIN_VAR[j] > VARIANT) ? (j == TIN_IRQ0 || j == TIN_IRQ1) :
                         input_remap_select_reg[TIN_SEL[j]] ? pin_s[TIN_PIN1[j]] : pin_s[TIN_PIN0[j]];
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tin_reg <= TIN_RST;
    end else begin
      tin_reg <= tin_next;
    end
  end

  assign o_timer0_ext_clock_in = tin_reg[TIN_TIMER0_EXT_CLOCK_IN];
  assign o_timer1_ext_clock_in = tin_reg[TIN_TIMER1_EXT_CLOCK_IN];
  assign o_timer2_ext_clock_in = tin_reg[TIN_TIMER2_EXT_CLOCK_IN];
  assign o_ext_irq0_in_n = tin_reg[TIN_IRQ0];
  assign o_ext_irq1_in_n = tin_reg[TIN_IRQ1];
  assign o_ext_irq2_in = tin_reg[TIN_IRQ2];

  // ****************************************
  // port a wake-up
  // ****************************************
  assign fall = porta_prev_reg & ~pin_s[7:0];

  // falling edge on enabled port a pin while asleep
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      porta_prev_reg <= 8'hff;
      o_wake <= 1'b0;
    end else begin
      porta_prev_reg <= pin_s[7:0];
      o_wake <= i_sleep && |(fall & wake_en_reg);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  logic first_reg;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  timer1_ext_clock_in_route_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !first_reg |-> o_timer1_ext_clock_in == $past(input_remap_select_reg[6] ? pin_s[33] : pin_s[4]))
    else $error("timer 1 clock from wrong pin");

  timer0_ext_clock_in_route_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !first_reg |-> o_timer0_ext_clock_in == $past(input_remap_select_reg[5] ? pin_s[32] : pin_s[2]))
    else $error("timer 0 clock from wrong pin");

  irq0_route_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !first_reg |-> o_ext_irq0_in_n == $past(input_remap_select_reg[2] ? pin_s[36] : pin_s[3]))
    else $error("irq 0 from wrong pin");

  irq2_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    VARIANT != 2'h3 |-> input_remap_select_reg[4] == 1'b0)
    else $error("irq 2 select set on a variant without it");

  timer2_ext_clock_in_route_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    VARIANT != 2'h0 && !first_reg |->
      o_timer2_ext_clock_in == $past(input_remap_select_reg[7] ? pin_s[34] : pin_s[18]))
    else $error("timer 2 clock from wrong pin");

  irq1_route_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !first_reg |-> o_ext_irq1_in_n == $past(input_remap_select_reg[3] ? pin_s[37] : pin_s[4]))
    else $error("irq 1 from wrong pin");

  irq2_route_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    VARIANT == 2'h3 && !first_reg |->
      o_ext_irq2_in == $past(input_remap_select_reg[4] ? pin_s[38] : pin_s[20]))
    else $error("irq 2 from wrong pin");

  t0_first_pin_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_timer_out_en[TOUT_T0_FIRST] && timer_output_remap_select_reg[0] |=>
      o_pin_oe[24] && o_pin_out[24] == $past(i_timer_out[TOUT_T0_FIRST]) && o_pin_oe[0] == !$past(dir_q[0]))
    else $error("timer 0 first output not moved to its remapped pin");

  chan_a_pin_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_timer_out_en[TOUT_CHAN_A] && !timer_output_remap_select_reg[2] |=>
      o_pin_oe[1] && o_pin_out[1] == $past(i_timer_out[TOUT_CHAN_A]))
    else $error("channel a not on its default pin");

  remap_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    bus_wr && i_wb_adr == OFS_OUT_REMAP |=> timer_output_remap_select_reg == $past(i_wb_dat[7:0] & OUT_MASK[VARIANT]))
    else $error("output remap write not masked or lost");

  port_reset_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    first_reg |-> data_q == '1 && dir_q == '1 && o_pin_oe == '0)
    else $error("ports not all ones after reset");

  dir_input_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !first_reg |-> o_pin_oe[15:8] == ~$past(dir_q[15:8]) && o_pin_out[15:8] == $past(data_q[15:8]))
    else $error("port b direction not honoured");

  bitop_rmw_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    bitop_go && !i_wb_dat[BITOP_DIR_BIT] |=> data_q[$past(bitop_port)*PORT_W +: PORT_W] == $past(bitop_new))
    else $error("bit operation did not write whole port back");

  wake_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_sleep && |(fall & wake_en_reg) |=> o_wake ##1 !o_wake || $past(i_sleep && |(fall & wake_en_reg)))
    else $error("wake not raised on enabled falling edge");

  ack_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus ack not a single pulse after one cycle");
endmodule

// [sim/tb.sv]
// testbench for the pin remap selector: registers, input and output routing, ports, wake
// assumes the largest variant and a classic wishbone slave that acks one cycle after the request
module tb
  import pin_remap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_sys_clk;
  logic i_rstn;
  logic i_wb_cyc;
  logic i_wb_stb;
  logic i_wb_we;
  logic [7:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat;
  logic [31:0] o_wb_dat;
  logic o_wb_ack;
  logic [NUM_PINS-1:0] i_pin_in;
  logic [NUM_PINS-1:0] o_pin_out;
  logic [NUM_PINS-1:0] o_pin_oe;
  logic [NUM_TOUT-1:0] i_timer_out;
  logic [NUM_TOUT-1:0] i_timer_out_en;
  logic o_timer0_ext_clock_in;
  logic o_timer1_ext_clock_in;
  logic o_timer2_ext_clock_in;
  logic o_ext_irq0_in_n;
  logic o_ext_irq1_in_n;
  logic o_ext_irq2_in;
  logic i_sleep;
  logic o_wake;
  int err_count;
  int comparisons;

  pin_remap_selector #(.VARIANT(2'h3)) dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .i_timer_out(i_timer_out), .i_timer_out_en(i_timer_out_en),
    .o_timer0_ext_clock_in(o_timer0_ext_clock_in), .o_timer1_ext_clock_in(o_timer1_ext_clock_in),
    .o_timer2_ext_clock_in(o_timer2_ext_clock_in), .o_ext_irq0_in_n(o_ext_irq0_in_n),
    .o_ext_irq1_in_n(o_ext_irq1_in_n), .o_ext_irq2_in(o_ext_irq2_in), .i_sleep(i_sleep), .o_wake(o_wake));

  always #5 i_sys_clk = ~i_sys_clk;

  // ****************************************
  // shared tasks
  // ****************************************
  task complete_run;
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string m);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  // request held until the edge that samples ack, then released for at least one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= s;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 16);
    if (o_wb_ack !== 1'b1) begin
      err_count++;
      $display("BAD %0t bus answer missing", $time);
      complete_run;
    end
    r = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, {24'h0, d}, 4'h1, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, 4'h1, r);
    check(64'(r), 64'(e), m);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    check(o_pin_oe, 64'h0, "pins driven after reset");
    check(o_pin_out, {NUM_PINS{1'b1}}, "pin drive after reset");
    rdc(OFS_IN_REMAP, 8'h00, "input remap reset");
    rdc(OFS_OUT_REMAP, 8'h00, "output remap reset");
    for (int p = 0; p < NUM_PORTS; p++) begin
      rdc(8'h40 + 8'(4 * p), 8'hff, "direction reset");
    end
  endtask

  task automatic t_regs;
    logic [31:0] r;
    wr(OFS_IN_REMAP, 8'hff);
    rdc(OFS_IN_REMAP, 8'hff, "input remap all bits");
    wr(OFS_OUT_REMAP, 8'hff);
    rdc(OFS_OUT_REMAP, 8'hff, "output remap all bits");
    // a write with lane 0 off must leave the register alone
    wb(1'b1, OFS_IN_REMAP, 32'h0, 4'h0, r);
    rdc(OFS_IN_REMAP, 8'hff, "masked lane write");
    wr(8'h60, 8'h55);
    rdc(8'h60, 8'h00, "unmapped read");
    rdc(OFS_BITOP, 8'h00, "bit op reads zero");
    wr(OFS_IN_REMAP, 8'h00);
    wr(OFS_OUT_REMAP, 8'h00);
  endtask

  task automatic t_inputs;
    int p0 [6] = '{2, 4, 18, 3, 4, 20};
    int p1 [6] = '{32, 33, 34, 36, 37, 38};
    int sb [6] = '{5, 6, 7, 2, 3, 4};
    logic [NUM_PINS-1:0] pv;
    logic [5:0] v;
    int pin;
    int oth;
    for (int k = 0; k < 6; k++) begin
      for (int s = 0; s < 2; s++) begin
        wr(OFS_IN_REMAP, 8'(s) << sb[k]);
        pin = s ? p1[k] : p0[k];
        oth = s ? p0[k] : p1[k];
        for (int lv = 0; lv < 2; lv++) begin
          pv = '0;
          pv[pin] = 1'(lv);
          pv[oth] = !lv;
          i_pin_in <= pv;
          repeat (5) @(posedge i_sys_clk);
          v = {o_ext_irq2_in, o_ext_irq1_in_n, o_ext_irq0_in_n, o_timer2_ext_clock_in,
               o_timer1_ext_clock_in, o_timer0_ext_clock_in};
          check(64'(v[k]), 64'(lv), "routed input level");
        end
      end
    end
    wr(OFS_IN_REMAP, 8'h00);
  endtask

  task automatic t_outputs;
    int p0 [9] = '{1, 16, 17, 0, 21, 19, 20, 51, 48};
    int p1 [9] = '{26, 27, 28, 24, 25, 30, 31, 40, 41};
    int og [9] = '{1, 0, 0, 1, 1, 1, 1, 1, 1};
    int sb [9] = '{2, 0, 1, 0, 1, 4, 5, 6, 7};
    int pin;
    int oth;
    for (int k = 0; k < 9; k++) begin
      for (int s = 0; s < 2; s++) begin
        wr(OFS_IN_REMAP, og[k] ? 8'h00 : 8'(s) << sb[k]);
        wr(OFS_OUT_REMAP, og[k] ? 8'(s) << sb[k] : 8'h00);
        i_timer_out_en <= 9'(1) << k;
        pin = s ? p1[k] : p0[k];
        oth = s ? p0[k] : p1[k];
        for (int lv = 0; lv < 2; lv++) begin
          i_timer_out <= lv ? '1 : '0;
          repeat (3) @(posedge i_sys_clk);
          check({61'h0, o_pin_oe[pin], o_pin_out[pin], o_pin_oe[oth]}, {61'h0, 2'b11 & {1'b1, 1'(lv)}, 1'b0},
                "routed timer output");
        end
      end
    end
    i_timer_out_en <= '0;
    wr(OFS_IN_REMAP, 8'h00);
    wr(OFS_OUT_REMAP, 8'h00);
  endtask

  task automatic t_ports;
    wr(8'h44, 8'hfe);
    repeat (3) @(posedge i_sys_clk);
    check({62'h0, o_pin_oe[8], o_pin_out[8]}, 64'h3, "output starts high");
    wr(8'h24, 8'h00);
    repeat (3) @(posedge i_sys_clk);
    check(64'(o_pin_out[8]), 64'h0, "output follows data");
    i_pin_in <= 64'h5a << 8;
    repeat (4) @(posedge i_sys_clk);
    // set data line 7 of port b, then clear direction line 1 of port b
    wr(OFS_BITOP, 8'h4f);
    wr(OFS_BITOP, 8'h89);
    rdc(8'h44, 8'hfc, "direction bit clear");
    wr(8'h44, 8'h00);
    repeat (3) @(posedge i_sys_clk);
    check(64'(o_pin_out[15:8]), 64'hda, "bit set rewrites port");
    check(64'(o_pin_oe[15:8]), 64'hff, "all lines output");
    wr(8'h44, 8'hff);
  endtask

  task automatic wake_try(input logic [7:0] en, input logic [7:0] fall, input int exp);
    int c;
    c = 0;
    wr(OFS_WAKE_EN, en);
    i_pin_in <= '1;
    repeat (4) @(posedge i_sys_clk);
    i_pin_in <= ~{56'h0, fall};
    repeat (8) begin
      @(posedge i_sys_clk);
      if (o_wake === 1'b1) c++;
    end
    check(64'(c), 64'(exp), "wake pulses");
  endtask

  task automatic t_wake;
    i_sleep <= 1'b1;
    wake_try(8'h04, 8'h04, 1);
    wake_try(8'h04, 8'h08, 0);
    wake_try(8'h18, 8'h18, 1);
    wake_try(8'hff, 8'h80, 1);
    i_sleep <= 1'b0;
    // awake: enabled falling edges must not raise wake
    wake_try(8'hff, 8'hff, 0);
  endtask

  // reset in mid-run must bring registers and pins back to their reset state
  task automatic t_rerun;
    wr(OFS_IN_REMAP, 8'h24);
    wr(8'h40, 8'h00);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    check(o_pin_oe, 64'h0, "pins driven after second reset");
    rdc(OFS_IN_REMAP, 8'h00, "input remap after second reset");
    rdc(8'h40, 8'hff, "direction after second reset");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    i_sys_clk = 1'b0;
    i_rstn = 1'b0;
    i_wb_cyc = 1'b0;
    i_wb_stb = 1'b0;
    i_wb_we = 1'b0;
    i_wb_adr = 8'h00;
    i_wb_sel = 4'h0;
    i_wb_dat = 32'h0;
    i_pin_in = '0;
    i_timer_out = '0;
    i_timer_out_en = '0;
    i_sleep = 1'b0;
    err_count = 0;
    comparisons = 0;
    repeat (3) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    t_reset;
    t_regs;
    t_inputs;
    t_outputs;
    t_ports;
    t_wake;
    t_rerun;
    complete_run;
  end
endmodule
